// ---- src/pcg_pkg.sv ----
// Purpose: shared constants for the port clock, key reset and group 0 block
// Assumes: 32-bit AXI4-Lite register bus, 16-bit registers in the low half
// Notes:   offsets are byte addresses of aligned words
package pcg_pkg;
  localparam logic [7:0]  OFS_CLK_CTL   = 8'h00;
  localparam logic [7:0]  OFS_GRP_SUM   = 8'h04;
  localparam logic [7:0]  OFS_G0_DATA   = 8'h10;
  localparam logic [7:0]  OFS_G0_IOEN   = 8'h14;
  localparam logic [7:0]  OFS_G0_PULL   = 8'h18;
  localparam logic [7:0]  OFS_G0_IFLG   = 8'h1C;
  localparam logic [7:0]  OFS_G0_ICTL   = 8'h20;
  localparam logic [7:0]  OFS_G0_FILT   = 8'h24;
  localparam logic [7:0]  OFS_G0_MODE   = 8'h28;
  localparam logic [7:0]  OFS_G0_FUNC   = 8'h2C;
  localparam int          NPINS         = 7;
  localparam int          HI_POS        = 8;
  localparam int          DBG_POS       = 8;
  localparam int          DIV_POS       = 4;
  localparam int          KEY_POS       = 2;
  localparam int          SRC_POS       = 0;
  localparam int          NGROUPS       = 13;
  localparam logic [1:0]  SRC_INTOSC    = 2'h0;
  localparam logic [1:0]  SRC_CRYSTAL   = 2'h1;
  localparam logic [1:0]  SRC_HSOSC     = 2'h2;
  localparam logic [1:0]  SRC_EXTCLK    = 2'h3;
  localparam logic [1:0]  KEY_OFF       = 2'h0;
  localparam logic [1:0]  KEY_PINS2     = 2'h1;
  localparam logic [1:0]  KEY_PINS3     = 2'h2;
  localparam logic [1:0]  KEY_PINS4     = 2'h3;
  localparam logic [1:0]  FN_DEDICATED  = 2'h0;
  localparam logic [1:0]  FN_UNIVERSAL  = 2'h1;
  localparam logic [15:0] RST_VAL       = 16'h0000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam int          FILT_SAMPLES  = 4;
endpackage

// ---- src/pcg_port_ctrl.sv ----
// Purpose: port controller clocking, key-entry reset, group summary and port group 0
// Assumes: pins already synchronous to clk; source clocks arrive as clk-rate ticks
// Notes:   divided operating clock is a one-cycle tick stream, not a real clock
//
// Operation
// - debug_run_enable 1 keeps operating tick running in debug, 0 stops it.
// - divider_select in clock register bits 7..4 sets source division ratio.
// - key_reset_config 3/2/1 resets when pins 3..0, 2..0 or 1..0 all low.
// - key_reset_config 0 disables key-entry reset entirely.
// - source_select picks internal, crystal, high-speed oscillator or external input.
// - oscillator sources divided by two to the power n; external input undivided.
// - divided tick period is the sampling interval of every enabled filter.
// - source codes whose oscillator is absent are refused on write.
// - summary bits 12..0 show pending flags per group; bits 15..13 read zero.
// - summary bit clears when software clears the causing per-port flag.
// - summary bits exist only for groups with interrupt support.
// - group 0 offers GPIO and input interrupt functions.
// - seven pins, fields at 14..8 and 6..0, reserved bits zero, reset zero.
// - mode 0 gives GPIO; mode 1 function 0 dedicated, 1 universal multiplexer.
// - edge select 1 flags falling edges, 0 flags rising edges.
// - flag reads 1 after its cause; writing 1 clears, writing 0 no effect.
// - filter enable 1 passes input through filter, 0 bypasses it.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pcg_port_ctrl #(
  parameter logic [3:0]  SRC_PRESENT = 4'hF,
  parameter logic [12:0] GRP_HAS_IRQ = 13'h0001
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic [3:0]          src_tick,
  input  wire logic                debug_mode,
  input  wire logic [12:1]         other_group_pending,
  input  wire logic [6:0]          pin_in,
  output logic      [6:0]          pin_out,
  output logic      [6:0]          pin_oe_n,
  output logic      [6:0]          pull_enable,
  output logic      [6:0]          pull_up,
  output logic      [6:0]          periph_sel,
  output logic      [13:0]         func_code,
  output logic                     op_tick,
  output logic                     key_reset_req,
  output logic                     irq,
  input  wire logic [31:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic      [1:0]          s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [31:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic      [31:0]         s_axi_rdata,
  output logic      [1:0]          s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] clk_ctl_r;
  logic [6:0]  out_r;
  logic [6:0]  ien_r;
  logic [6:0]  oen_r;
  logic [6:0]  pdpu_r;
  logic [6:0]  ren_r;
  logic [6:0]  iflag_r;
  logic [6:0]  edge_r;
  logic [6:0]  ie_r;
  logic [6:0]  filt_r;
  logic [6:0]  sel_r;
  logic [13:0] fnc_r;
  logic [14:0] div_cnt_r;
  logic [6:0]  filt_val_r;
  logic [6:0]  prev_r;
  logic [12:0] summary;
  logic [6:0]  pin_eff;
  logic [1:0]  src;
  logic [3:0]  divn;
  logic        src_pulse;
  logic        div_hit;
  logic        op_tick_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: address and data taken in either order, latched until both seen
  logic [7:0]  aw_addr_r;
  logic        aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        w_have_r;
  logic        wr_go;
  logic        wr_hit;
  logic [15:0] wd;
  logic        wlo;
  logic        whi;

  // each ready stays low from its own handshake until the answer is taken,
  // so a second write can never overtake the one being answered
  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wd    = w_data_r[15:0];
  assign wlo   = wr_go && w_strb_r[0];
  assign whi   = wr_go && w_strb_r[1];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_have_r     <= 1'b0;
      aw_addr_r     <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_have_r     <= 1'b0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r     <= 1'b1;
      aw_addr_r     <= s_axi_awaddr[7:0];
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      w_have_r     <= 1'b0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_have_r     <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r     <= 1'b1;
      w_data_r     <= s_axi_wdata;
      w_strb_r     <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_r && !s_axi_bvalid;
    end
  end

  always_comb begin
    case (aw_addr_r)
      pcg_pkg::OFS_CLK_CTL, pcg_pkg::OFS_GRP_SUM, pcg_pkg::OFS_G0_DATA,
      pcg_pkg::OFS_G0_IOEN, pcg_pkg::OFS_G0_PULL, pcg_pkg::OFS_G0_IFLG,
      pcg_pkg::OFS_G0_ICTL, pcg_pkg::OFS_G0_FILT, pcg_pkg::OFS_G0_MODE,
      pcg_pkg::OFS_G0_FUNC: wr_hit = 1'b1;
      default:              wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pcg_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? pcg_pkg::RESP_OKAY : pcg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock control register; a refused source code leaves the old source in place
  always_ff @(posedge clk) begin
    if (!rstn) begin
      clk_ctl_r <= pcg_pkg::RST_VAL;
    end else if (aw_addr_r == pcg_pkg::OFS_CLK_CTL) begin
      if (wlo) begin
        clk_ctl_r[7:2] <= wd[7:2];
        if (SRC_PRESENT[wd[1:0]])
          clk_ctl_r[1:0] <= wd[1:0];
      end
      if (whi)
        clk_ctl_r[pcg_pkg::DBG_POS] <= wd[pcg_pkg::DBG_POS];
    end
  end

  // group 0 control registers, all zero at reset, reserved bits never stored
  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_r  <= 7'h00;
      ien_r  <= 7'h00;
      oen_r  <= 7'h00;
      pdpu_r <= 7'h00;
      ren_r  <= 7'h00;
      edge_r <= 7'h00;
      ie_r   <= 7'h00;
      filt_r <= 7'h00;
      sel_r  <= 7'h00;
      fnc_r  <= 14'h0000;
    end else begin
      if (aw_addr_r == pcg_pkg::OFS_G0_DATA && whi) out_r <= wd[14:8];
      if (aw_addr_r == pcg_pkg::OFS_G0_IOEN) begin
        if (whi) ien_r <= wd[14:8];
        if (wlo) oen_r <= wd[6:0];
      end
      if (aw_addr_r == pcg_pkg::OFS_G0_PULL) begin
        if (whi) pdpu_r <= wd[14:8];
        if (wlo) ren_r <= wd[6:0];
      end
      if (aw_addr_r == pcg_pkg::OFS_G0_ICTL) begin
        if (whi) edge_r <= wd[14:8];
        if (wlo) ie_r <= wd[6:0];
      end
      if (aw_addr_r == pcg_pkg::OFS_G0_FILT && wlo) filt_r <= wd[6:0];
      if (aw_addr_r == pcg_pkg::OFS_G0_MODE && wlo) sel_r <= wd[6:0];
      if (aw_addr_r == pcg_pkg::OFS_G0_FUNC) begin
        if (wlo) fnc_r[7:0] <= wd[7:0];
        if (whi) fnc_r[13:8] <= wd[13:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operating tick: oscillator tick divided by 2**n, external tick undivided, gated in debug mode
  assign src  = clk_ctl_r[1:0];
  assign divn = clk_ctl_r[7:4];
  assign src_pulse = src_tick[src] && !(debug_mode && !clk_ctl_r[pcg_pkg::DBG_POS]);
  assign div_hit = (src == pcg_pkg::SRC_EXTCLK) ||
                   ((div_cnt_r & ((15'h0001 << divn) - 15'h0001)) ==
                    ((15'h0001 << divn) - 15'h0001));
  assign op_tick_nxt = src_pulse && div_hit;

  // counter is cleared only by reset: a new divider takes effect at once, so the
  // first operating period after a change may come short
  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_cnt_r <= 15'h0000;
      op_tick   <= 1'b0;
    end else begin
      if (src_pulse) div_cnt_r <= div_cnt_r + 15'h0001;
      op_tick <= op_tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pin filter: a new level is accepted after FILT_SAMPLES equal samples
  genvar g;
  generate
    for (g = 0; g < pcg_pkg::NPINS; g++) begin : g_pin
      logic [2:0] cnt_r;
      logic       val_r;
      // each pin keeps its own filtered level so no vector has several writers
      assign filt_val_r[g] = val_r;
      always_ff @(posedge clk) begin
        if (!rstn) begin
          cnt_r <= 3'h0;
          val_r <= 1'b0;
        end else if (op_tick_nxt) begin
          if (pin_in[g] == val_r) begin
            cnt_r <= 3'h0;
          end else if (cnt_r == 3'(pcg_pkg::FILT_SAMPLES - 1)) begin
            cnt_r <= 3'h0;
            val_r <= pin_in[g];
          end else begin
            cnt_r <= cnt_r + 3'h1;
          end
        end
      end
      // gpio input gated by its enable; peripheral mode hides the pin
      assign pin_eff[g] = ien_r[g] && !sel_r[g] &&
                          (filt_r[g] ? filt_val_r[g] : pin_in[g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags: set wins over a clearing write in the same cycle
  // edges are judged on the gated input, so an input held disabled raises no flag
  logic [6:0] edge_hit;
  assign edge_hit = (edge_r & prev_r & ~pin_eff) |
                    (~edge_r & ~prev_r & pin_eff);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev_r  <= 7'h00;
      iflag_r <= 7'h00;
    end else begin
      prev_r <= pin_eff;
      if (aw_addr_r == pcg_pkg::OFS_G0_IFLG && wlo)
        iflag_r <= (iflag_r & ~wd[6:0]) | edge_hit;
      else
        iflag_r <= iflag_r | edge_hit;
    end
  end

  // summary is derived, so it follows the flags with no write path
  // groups without interrupt support read zero through the parameter mask
  assign summary = {other_group_pending, |iflag_r} & GRP_HAS_IRQ;

  ////////////////////////////////////////////////////////////////////////////
  // pin drive, key reset and interrupt outputs, all registered
  // raw pins, not filtered: a held key combination must reset even when
  // the operating tick is stopped
  logic key_low;
  always_comb begin
    case (clk_ctl_r[3:2])
      pcg_pkg::KEY_PINS4: key_low = (pin_in[3:0] == 4'h0);
      pcg_pkg::KEY_PINS3: key_low = (pin_in[2:0] == 3'h0);
      pcg_pkg::KEY_PINS2: key_low = (pin_in[1:0] == 2'h0);
      default:            key_low = 1'b0;
    endcase
  end

  // pulls act only on undriven gpio pins; peripheral mode leaves the pin to its owner
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_out       <= 7'h00;
      pin_oe_n      <= 7'h7F;
      pull_enable   <= 7'h00;
      pull_up       <= 7'h00;
      periph_sel    <= 7'h00;
      func_code     <= 14'h0000;
      key_reset_req <= 1'b0;
      irq           <= 1'b0;
    end else begin
      pin_out       <= out_r;
      pin_oe_n      <= ~(oen_r & ~sel_r);
      pull_enable   <= ren_r & ~oen_r & ~sel_r;
      pull_up       <= pdpu_r;
      periph_sel    <= sel_r;
      func_code     <= fnc_r;
      key_reset_req <= key_low;
      irq           <= |(iflag_r & ie_r) || |summary[12:1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one read at a time, answer one cycle after the address
  // the register is chosen from the live address; the master holds it
  // until arready has been seen, so the sample is taken while it stands
  logic [15:0] rd_val;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr[7:0])
      pcg_pkg::OFS_CLK_CTL: rd_val = {7'h00, clk_ctl_r[8:0]};
      pcg_pkg::OFS_GRP_SUM: rd_val = {3'h0, summary};
      pcg_pkg::OFS_G0_DATA: rd_val = {1'b0, out_r, 1'b0, pin_eff};
      pcg_pkg::OFS_G0_IOEN: rd_val = {1'b0, ien_r, 1'b0, oen_r};
      pcg_pkg::OFS_G0_PULL: rd_val = {1'b0, pdpu_r, 1'b0, ren_r};
      pcg_pkg::OFS_G0_IFLG: rd_val = {9'h000, iflag_r};
      pcg_pkg::OFS_G0_ICTL: rd_val = {1'b0, edge_r, 1'b0, ie_r};
      pcg_pkg::OFS_G0_FILT: rd_val = {9'h000, filt_r};
      pcg_pkg::OFS_G0_MODE: rd_val = {9'h000, sel_r};
      pcg_pkg::OFS_G0_FUNC: rd_val = {2'h0, fnc_r};
      default: begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pcg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {16'h0000, rd_val};
      s_axi_rresp   <= rd_hit ? pcg_pkg::RESP_OKAY : pcg_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule // pcg_port_ctrl
`default_nettype wire

// ---- tb/pcg_monitor.sv ----
// Purpose: protocol and pin checks on the port controller ports
// Assumes: registered outputs, synchronous active-low reset
// Notes:   register contents are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module pcg_monitor (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [6:0]  pin_in,
  input wire logic [6:0]  pin_oe_n,
  input wire logic [6:0]  pull_enable,
  input wire logic [6:0]  periph_sel,
  input wire logic        key_reset_req,
  input wire logic [3:0]  src_tick,
  input wire logic        op_tick,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  sequence wr_both_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////
  reset_oe_a: assert property (disable iff (1'b0) !rstn |=> pin_oe_n == 7'h7F)
    else $error("pins driven during reset");
  key_release_a: assert property (pin_in[1:0] != 2'h0 |=> !key_reset_req)
    else $error("key reset held with a key up");
  key_cause_a: assert property (key_reset_req |-> $past(pin_in[1:0]) == 2'h0)
    else $error("key reset without low keys");
  tick_cause_a: assert property (op_tick |-> $past(src_tick) != 4'h0)
    else $error("operating tick without source tick");
  periph_hiz_a: assert property ((periph_sel & ~pin_oe_n) == 7'h00)
    else $error("gpio drive in peripheral mode");
  pull_hiz_a: assert property ((pull_enable & ~pin_oe_n) == 7'h00)
    else $error("pull active on driven pin");
  write_resp_a: assert property (wr_both_s |-> ##2 s_axi_bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  read_resp_a: assert property (rd_take_s |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0)
    else $error("read answer late or upper half set");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed while waiting");
endmodule // pcg_monitor
bind pcg_port_ctrl pcg_monitor u_mon (.*);
`default_nettype wire

// ---- tb/test_port_clock_keyreset_group0.sv ----
// Purpose: register, key reset, tick, filter and interrupt tests
// Assumes: AXI4-Lite master tasks, high-speed source absent
// Notes:   ofs[] indexes follow the register table order
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module test_port_clock_keyreset_group0;
  logic        clk = 1'b0, rstn = 1'b0, debug_mode = 1'b0;
  logic [3:0]  src_tick = 4'h0, s_axi_wstrb = 4'hF;
  logic [12:1] other_group_pending = 12'h000;
  logic [6:0]  pin_in = 7'h00, pin_out, pin_oe_n, pull_enable, pull_up, periph_sel;
  logic [13:0] func_code;
  logic        op_tick, key_reset_req, irq, s_axi_awready, s_axi_wready;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [31:0] s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          errors = 0, checked = 0, ticks = 0;
  logic [7:0]  ofs [10] = '{pcg_pkg::OFS_CLK_CTL, pcg_pkg::OFS_GRP_SUM,
    pcg_pkg::OFS_G0_DATA, pcg_pkg::OFS_G0_IOEN, pcg_pkg::OFS_G0_PULL,
    pcg_pkg::OFS_G0_IFLG, pcg_pkg::OFS_G0_ICTL, pcg_pkg::OFS_G0_FILT,
    pcg_pkg::OFS_G0_MODE, pcg_pkg::OFS_G0_FUNC};
  // writable mask seen after writing all ones; source 3 is present
  logic [15:0] msk [10] = '{16'h01FF, 16'h0000, 16'h7F00, 16'h7F7F, 16'h7F7F,
    16'h0000, 16'h7F7F, 16'h007F, 16'h007F, 16'h3FFF};

  pcg_port_ctrl #(.SRC_PRESENT(4'hB)) u_dut (.*);
  always #20 clk = ~clk;
  // counted on the falling edge so the count never races the tests
  always @(negedge clk) if (op_tick === 1'b1) ticks++;
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] er = pcg_pkg::RESP_OKAY);
    @(posedge clk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no cycle limit here: only the watchdog may end a wait for the answer
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input logic [1:0] er = pcg_pkg::RESP_OKAY);
    @(posedge clk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, {16'h0, e})
    `CHK(s_axi_rresp, er)
  endtask
  task automatic run_ticks(input logic [15:0] ctl, input logic [3:0] pat,
                           input logic dbg, input int n, input int exp);
    wr(ofs[0], ctl);
    debug_mode <= dbg;
    @(posedge clk);
    ticks = 0;
    src_tick <= pat;
    repeat (n) @(posedge clk);
    src_tick <= 4'h0;
    repeat (4) @(posedge clk);
    `CHK(ticks, exp)
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #2000000;
    errors++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge clk);
    `CHK(pin_oe_n, 7'h7F)
    rstn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd(ofs[i], pcg_pkg::RST_VAL);
      wr(ofs[i], 16'hFFFF);
      rd(ofs[i], msk[i]);
      wr(ofs[i], 16'h0000);
    end
    rd(8'h40, 16'h0000, pcg_pkg::RESP_SLVERR);
    wr(8'h40, 16'hFFFF, pcg_pkg::RESP_SLVERR);
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      for (int k = 2; k < 5; k++) begin
        wr(ofs[0], {12'h0, 2'(c), 2'h0});
        pin_in <= 7'h7F << k;
        repeat (3) @(posedge clk);
        `CHK(key_reset_req, 1'((c != 0) && (k > c)))
        pin_in <= 7'h7F;
        repeat (3) @(posedge clk);
        `CHK(key_reset_req, 1'b0)
      end
    end
    $display("test key reset done");
    run_ticks(16'h0020, 4'h1, 1'b0, 16, 4);
    run_ticks(16'h0002, 4'h1, 1'b0, 4, 4);
    run_ticks(16'h00F3, 4'h8, 1'b0, 5, 5);
    run_ticks(16'h0001, 4'h1, 1'b0, 8, 0);
    run_ticks(16'h0000, 4'h1, 1'b1, 8, 0);
    run_ticks(16'h0100, 4'h1, 1'b1, 8, 8);
    $display("test operating tick done");
    pin_in <= 7'h01;
    wr(ofs[3], 16'h7F00);
    wr(ofs[7], 16'h0001);
    run_ticks(16'h0100, 4'h1, 1'b1, 8, 8);
    rd(ofs[2], 16'h0001);
    pin_in <= 7'h00;
    repeat (3) @(posedge clk);
    rd(ofs[2], 16'h0001);
    run_ticks(16'h0100, 4'h1, 1'b1, 8, 8);
    rd(ofs[2], 16'h0000);
    wr(ofs[7], 16'h0000);
    pin_in <= 7'h01;
    repeat (3) @(posedge clk);
    rd(ofs[2], 16'h0001);
    $display("test filter done");
    pin_in <= 7'h02;
    other_group_pending <= 12'hFFF;
    wr(ofs[6], 16'h027F);
    wr(ofs[5], 16'h007F);
    pin_in <= 7'h01;
    repeat (3) @(posedge clk);
    rd(ofs[5], 16'h0003);
    rd(ofs[1], 16'h0001);
    `CHK(irq, 1'b1)
    other_group_pending <= 12'h000;
    wr(ofs[5], 16'h0001);
    rd(ofs[5], 16'h0002);
    wr(ofs[5], 16'h0000);
    rd(ofs[5], 16'h0002);
    wr(ofs[5], 16'h0002);
    rd(ofs[1], 16'h0000);
    @(posedge clk);
    `CHK(irq, 1'b0)
    $display("test interrupts done");
    wr(ofs[3], 16'h007F);
    wr(ofs[2], 16'h5500);
    wr(ofs[8], 16'h0041);
    wr(ofs[9], 16'h1001);
    @(posedge clk);
    `CHK(pin_out, 7'h55)
    `CHK(pin_oe_n, 7'h41)
    `CHK(periph_sel, 7'h41)
    `CHK(func_code, 14'h1001)
    wr(ofs[4], 16'h2A7F);
    @(posedge clk);
    `CHK(pull_enable, 7'h00)
    `CHK(pull_up, 7'h2A)
    wr(ofs[3], 16'h0000);
    @(posedge clk);
    `CHK(pull_enable, 7'h3E)
    `CHK(pin_oe_n, 7'h7F)
    $display("test functions done");
    test_done();
  end
endmodule // test_port_clock_keyreset_group0
`default_nettype wire
